// File: rtl/gpio_bank_pkg.sv
package gpio_bank_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_COUNT = 64;

  // Register byte offsets
  localparam logic [7:0] OFS_LEVEL_LOW = 8'h00;
  localparam logic [7:0] OFS_VALUE_LOW = 8'h04;
  localparam logic [7:0] OFS_ENABLE_LOW = 8'h08;
  localparam logic [7:0] OFS_SELECT_LOW = 8'h0C;
  localparam logic [7:0] OFS_LEVEL_HIGH = 8'hB0;
  localparam logic [7:0] OFS_VALUE_HIGH = 8'hB4;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'hB8;
  localparam logic [7:0] OFS_SELECT_HIGH = 8'hBC;
  localparam logic [7:0] OFS_EVENT = 8'hC0;
  localparam logic [7:0] OFS_EVENT_MASK = 8'hC4;

  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Pins that exist per direction
  localparam logic [63:0] INPUT_PINS_DEF = 64'h9FFF_FFFF_FFFF_FD7F;
  localparam logic [63:0] OUTPUT_PINS_DEF = 64'h9C7F_FFFF_FFFF_FD7F;

  // Edge events
  localparam int unsigned EVT_INPUTS = 7;
  localparam int unsigned EVT_RISE_LSB = 0;
  localparam int unsigned EVT_FALL_LSB = 8;
  localparam int unsigned ARM_CYCLES = 3;

  // Boot clock pins and divider
  localparam int unsigned AUDIO_MCLK_PIN = 11;
  localparam int unsigned AUDIO_OUT_PIN = 37;
  localparam int unsigned REF_DIVIDE = 16;
  localparam int unsigned REF_HALF = REF_DIVIDE / 2;
  localparam int unsigned REF_CNT_W = $clog2(REF_HALF);

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 64
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: rtl/edge_events.sv
`timescale 1ns/1ps
`default_nettype none
module edge_events #(
  parameter int unsigned INPUTS = gpio_bank_pkg::EVT_INPUTS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic armed,
  input wire logic [INPUTS-1:0] level,
  input wire logic [31:0] clear_bits,
  output logic [31:0] flags_q
);

  logic [INPUTS-1:0] prev_q;
  logic [31:0] set_bits;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q <= '0;
    end
    else
    begin
      prev_q <= level;
    end
  end

  always_comb
  begin
    set_bits = '0;
    if (armed)
    begin
      set_bits[gpio_bank_pkg::EVT_RISE_LSB +: INPUTS] = level & ~prev_q;
      set_bits[gpio_bank_pkg::EVT_FALL_LSB +: INPUTS] = ~level & prev_q;
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_q <= gpio_bank_pkg::RST_CTRL;
    end
    else
    begin
      flags_q <= (flags_q & ~clear_bits) | set_bits;
    end
  end

endmodule
`default_nettype wire

// File: rtl/gpio_banks.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gpio_banks #(
  parameter logic [63:0] INPUT_PINS = gpio_bank_pkg::INPUT_PINS_DEF,
  parameter logic [63:0] OUTPUT_PINS = gpio_bank_pkg::OUTPUT_PINS_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] addr,
  input wire logic [gpio_bank_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [gpio_bank_pkg::DATA_W-1:0] rdata,
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  input wire logic [63:0] primary_out,
  input wire logic [63:0] primary_oe,
  input wire logic crystal_reference_clock,
  output logic event_pending
);

  logic [31:0] drive_value_low_q;
  logic [31:0] drive_enable_low_q;
  logic [31:0] pin_select_low_q;
  logic [31:0] drive_value_high_q;
  logic [31:0] drive_enable_high_q;
  logic [31:0] pin_select_high_q;
  logic [31:0] edge_event_mask_q;
  logic [31:0] edge_event_flags;
  logic [31:0] clear_bits;
  logic [63:0] level_sync;
  logic [63:0] drive_value;
  logic [63:0] drive_enable;
  logic [63:0] pin_select;
  logic [1:0] arm_cnt_q;
  logic armed_q;
  logic ref_prev_q;
  logic ref_rise;
  logic [gpio_bank_pkg::REF_CNT_W-1:0] ref_cnt_q;
  logic ref_div_q;
  logic mclk_boot_q;
  logic audio_boot_q;
  logic [31:0] rdata_d;

  function automatic logic hit(
    input logic [gpio_bank_pkg::ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    hit = (a == ofs);
  endfunction

  assign drive_value = {drive_value_high_q, drive_value_low_q};
  assign drive_enable = {drive_enable_high_q, drive_enable_low_q};
  assign pin_select = {pin_select_high_q, pin_select_low_q};

  // Absent pins read as zero
  pin_sync #(
    .WIDTH(gpio_bank_pkg::PIN_COUNT)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pin_in & INPUT_PINS),
    .sync_out(level_sync)
  );

  // Hold off edges until the synchroniser has filled, else a pin
  // sitting high at reset would report a false rising edge.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arm_cnt_q <= '0;
      armed_q <= 1'b0;
    end
    else if (!armed_q)
    begin
      arm_cnt_q <= arm_cnt_q + 2'h1;
      armed_q <= (arm_cnt_q == 2'(gpio_bank_pkg::ARM_CYCLES - 1));
    end
  end

  assign clear_bits = (wr_en && hit(addr, gpio_bank_pkg::OFS_EVENT)) ? wdata : gpio_bank_pkg::READ_ZERO;

  edge_events #(
    .INPUTS(gpio_bank_pkg::EVT_INPUTS)
  ) u_events (
    .clk(clk),
    .reset_n(reset_n),
    .armed(armed_q),
    .level(level_sync[gpio_bank_pkg::EVT_INPUTS-1:0]),
    .clear_bits(clear_bits),
    .flags_q(edge_event_flags)
  );

  assign event_pending = |(edge_event_flags & edge_event_mask_q);

  // Low bank control
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_value_low_q <= gpio_bank_pkg::RST_CTRL;
      drive_enable_low_q <= gpio_bank_pkg::RST_CTRL;
      pin_select_low_q <= gpio_bank_pkg::RST_CTRL;
    end
    else if (wr_en)
    begin
      if (hit(addr, gpio_bank_pkg::OFS_VALUE_LOW))
      begin
        drive_value_low_q <= wdata;
      end
      if (hit(addr, gpio_bank_pkg::OFS_ENABLE_LOW))
      begin
        drive_enable_low_q <= wdata;
      end
      if (hit(addr, gpio_bank_pkg::OFS_SELECT_LOW))
      begin
        pin_select_low_q <= wdata;
      end
    end
  end

  // High bank control
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_value_high_q <= gpio_bank_pkg::RST_CTRL;
      drive_enable_high_q <= gpio_bank_pkg::RST_CTRL;
      pin_select_high_q <= gpio_bank_pkg::RST_CTRL;
    end
    else if (wr_en)
    begin
      if (hit(addr, gpio_bank_pkg::OFS_VALUE_HIGH))
      begin
        drive_value_high_q <= wdata;
      end
      if (hit(addr, gpio_bank_pkg::OFS_ENABLE_HIGH))
      begin
        drive_enable_high_q <= wdata;
      end
      if (hit(addr, gpio_bank_pkg::OFS_SELECT_HIGH))
      begin
        pin_select_high_q <= wdata;
      end
    end
  end

  // Event mask
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      edge_event_mask_q <= gpio_bank_pkg::RST_CTRL;
    end
    else if (wr_en && hit(addr, gpio_bank_pkg::OFS_EVENT_MASK))
    begin
      edge_event_mask_q <= wdata;
    end
  end

  // Reference is sampled, so the divided clock counts its rising edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_prev_q <= 1'b0;
    end
    else
    begin
      ref_prev_q <= crystal_reference_clock;
    end
  end

  assign ref_rise = crystal_reference_clock & ~ref_prev_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_cnt_q <= '0;
      ref_div_q <= 1'b0;
    end
    else if (ref_rise)
    begin
      if (ref_cnt_q == gpio_bank_pkg::REF_CNT_W'(gpio_bank_pkg::REF_HALF - 1))
      begin
        ref_cnt_q <= '0;
        ref_div_q <= ~ref_div_q;
      end
      else
      begin
        ref_cnt_q <= ref_cnt_q + gpio_bank_pkg::REF_CNT_W'(1);
      end
    end
  end

  // Boot clocks stop for good once software first selects the pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mclk_boot_q <= 1'b1;
      audio_boot_q <= 1'b1;
    end
    else
    begin
      if (pin_select[gpio_bank_pkg::AUDIO_MCLK_PIN])
      begin
        mclk_boot_q <= 1'b0;
      end
      if (pin_select[gpio_bank_pkg::AUDIO_OUT_PIN])
      begin
        audio_boot_q <= 1'b0;
      end
    end
  end

  // Pin drive mux
  always_comb
  begin
    for (int i = 0; i < gpio_bank_pkg::PIN_COUNT; i++)
    begin
      if (pin_select[i] && OUTPUT_PINS[i])
      begin
        pin_oe[i] = drive_enable[i];
        pin_out[i] = drive_enable[i] & drive_value[i];
      end
      else
      begin
        pin_oe[i] = primary_oe[i];
        pin_out[i] = primary_out[i];
      end
    end
    // Reference passes straight through to pin 11: no flop stands in its path
    if (mclk_boot_q)
    begin
      pin_oe[gpio_bank_pkg::AUDIO_MCLK_PIN] = 1'b1;
      pin_out[gpio_bank_pkg::AUDIO_MCLK_PIN] = crystal_reference_clock;
    end
    if (audio_boot_q)
    begin
      pin_oe[gpio_bank_pkg::AUDIO_OUT_PIN] = 1'b1;
      pin_out[gpio_bank_pkg::AUDIO_OUT_PIN] = ref_div_q;
    end
  end

  // Read decode; clear register reads back the event flags
  always_comb
  begin
    rdata_d = gpio_bank_pkg::READ_ZERO;
    unique case (addr)
      gpio_bank_pkg::OFS_LEVEL_LOW: rdata_d = level_sync[31:0];
      gpio_bank_pkg::OFS_VALUE_LOW: rdata_d = drive_value_low_q;
      gpio_bank_pkg::OFS_ENABLE_LOW: rdata_d = drive_enable_low_q;
      gpio_bank_pkg::OFS_SELECT_LOW: rdata_d = pin_select_low_q;
      gpio_bank_pkg::OFS_LEVEL_HIGH: rdata_d = level_sync[63:32];
      gpio_bank_pkg::OFS_VALUE_HIGH: rdata_d = drive_value_high_q;
      gpio_bank_pkg::OFS_ENABLE_HIGH: rdata_d = drive_enable_high_q;
      gpio_bank_pkg::OFS_SELECT_HIGH: rdata_d = pin_select_high_q;
      gpio_bank_pkg::OFS_EVENT: rdata_d = edge_event_flags;
      gpio_bank_pkg::OFS_EVENT_MASK: rdata_d = edge_event_mask_q;
      default: rdata_d = gpio_bank_pkg::READ_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= gpio_bank_pkg::READ_ZERO;
    end
    else if (rd_en)
    begin
      rdata <= rdata_d;
    end
    else
    begin
      rdata <= gpio_bank_pkg::READ_ZERO;
    end
  end

endmodule
`default_nettype wire

// File: verification/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] ext_val,
  output logic [63:0] pin_in
);
  // Far side drives every pin the block leaves floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// File: verification/gpio_banks_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module banks_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [63:0] pin_in,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] primary_oe,
  input wire logic crystal_reference_clock,
  input wire logic event_pending
);
  logic [31:0] mask_q;
  logic [1:0] low_q;
  logic [1:0] gone_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q <= 32'h0;
      low_q <= 2'h0;
      gone_q <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == 8'hC4)
        mask_q <= wdata;
      if (addr == 8'h08)
        low_q[0] <= wdata[0];
      if (addr == 8'h0C)
        low_q[1] <= wdata[0];
      gone_q <= gone_q | {addr == 8'hBC && wdata[5], addr == 8'h0C && wdata[11]};
    end
  end
  sequence sync_then_pend;
    ##3 event_pending;
  endsequence
  a_mask_read_back: assert property (rd_en && addr == 8'hC4 |=> rdata == mask_q)
    else $error("mask readback");
  a_mask_off_quiet: assert property (wr_en && addr == 8'hC4 && wdata == 32'h0 |=> !event_pending)
    else $error("pending unmasked");
  a_rise_pends: assert property ($rose(pin_in[0]) && mask_q[0] |-> sync_then_pend)
    else $error("rise not pending");
  a_spare_flags_zero: assert property (rd_en && addr == 8'hC0 |=> rdata[31:15] == 17'h0 && !rdata[7])
    else $error("spare flag set");
  a_primary_passes: assert property (!low_q[1] |-> pin_oe[0] == primary_oe[0])
    else $error("primary oe");
  a_plain_enable: assert property (low_q[1] |-> pin_oe[0] == low_q[0])
    else $error("plain oe");
  a_ref_clock_out: assert property (!gone_q[0] |-> pin_oe[11] && pin_out[11] == crystal_reference_clock)
    else $error("ref clock pin");
  a_div_steady: assert property (!gone_q[1] && $changed(pin_out[37]) |=> ($stable(pin_out[37]) || gone_q[1]) [*8])
    else $error("divided clock");
endmodule
bind gpio_banks banks_checker chk_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .primary_oe(primary_oe),
  .crystal_reference_clock(crystal_reference_clock), .event_pending(event_pending));
`default_nettype wire

// File: verification/tb_general_purpose_io_banks.sv
`timescale 1ns/1ps
`default_nettype none
module tb_general_purpose_io_banks;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic [31:0] rdata;
  logic [63:0] pin_in;
  logic [63:0] pin_out;
  logic [63:0] pin_oe;
  logic [63:0] prim = 64'h0;
  logic [63:0] prim_out = 64'h0;
  logic [63:0] ext_val = 64'hE123_4567_89AB_CDEF;
  logic [1:0] ph = 2'h0;
  logic event_pending;
  logic [7:0] ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'hB4, 8'hB8, 8'hBC, 8'hC4};
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  gpio_banks dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .primary_out(prim_out), .primary_oe(prim),
    .crystal_reference_clock(ph[1]), .event_pending(event_pending));
  pin_world far_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Reference clock at a quarter of the bus clock
  always @(posedge clk)
  begin
    ph <= ph + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Extra edge after the strobe so back-to-back calls never reassign it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(posedge clk);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  // Pattern keeps select bits of both clock pins clear
  task automatic t_rw;
    for (int i = 0; i < 7; i++)
    begin
      rc(ofs[i], 32'h0);
      wr(ofs[i], 32'hC33C_5255);
      rc(ofs[i], 32'hC33C_5255);
      wr(ofs[i], 32'h0);
    end
    wr(8'hC0, 32'hFFFF_FFFF);
    rc(8'hC0, 32'h0);
    rc(8'h10, 32'h0);
  endtask
  task automatic t_boot;
    logic b;
    int n;
    chk("ref pin", {ph[1], 1'h1}, {pin_out[11], pin_oe[11]});
    for (int k = 0; k < 2; k++)
    begin
      b = pin_out[37];
      n = 0;
      while (pin_out[37] === b && n < 99)
      begin
        @(posedge clk);
        n++;
      end
    end
    chk("div period", 64'h20, n);
    wr(8'h0C, 32'h800);
    wr(8'hBC, 32'h20);
    wr(8'h0C, 32'h0);
    wr(8'hBC, 32'h0);
    chk("boot off", 64'h0, pin_oe & 64'h0000_0020_0000_0800);
  endtask
  task automatic t_levels;
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'hFFFF_FFFF);
    repeat (2) @(posedge clk);
    rc(8'h00, ext_val[31:0] & 32'hFFFF_FD7E);
    rc(8'hB0, ext_val[63:32] & 32'h9FFF_FFFF);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h0);
  endtask
  task automatic t_mux;
    prim <= 64'h0000_0008_0000_0000;
    @(posedge clk);
    chk("primary", 64'h2, {pin_oe[35], pin_out[35]});
    for (int k = 0; k < 3; k++)
    begin
      wr(8'hBC - 8'(4 * k), 32'h8);
      chk("plain", 64'(k + (k > 0)), {pin_oe[35], pin_out[35]});
    end
    for (int k = 0; k < 3; k++)
      wr(8'hB4 + 8'(4 * k), 32'h0);
    prim <= 64'h0;
  endtask
  task automatic t_events;
    ext_val[6:0] <= 7'h0;
    repeat (4) @(posedge clk);
    wr(8'hC4, 32'h4141);
    wr(8'hC0, 32'hFFFF_FFFF);
    ext_val[6:0] <= 7'h41;
    repeat (4) @(posedge clk);
    rc(8'hC0, 32'h41);
    chk("pending", 64'h1, event_pending);
    ext_val[6:0] <= 7'h0;
    wr(8'hC0, 32'h41);
    wr(8'hC0, 32'h0);
    rc(8'hC0, 32'h4100);
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_rw();
    t_boot();
    t_levels();
    t_mux();
    t_events();
    give_verdict();
  end
endmodule
`default_nettype wire
